// [dsx_cfg.svh]
// Offsets, field positions, reset values and codes of the shift/subtract/table datapath.
// Assumes inclusion by bare name; defines only.
`ifndef DSX_CFG_SVH
`define DSX_CFG_SVH
`define DSX_A_CTRL   12'h000
`define DSX_A_OPA    12'h004
`define DSX_A_OPB    12'h008
`define DSX_A_LIT    12'h00c
`define DSX_A_STAT   12'h010
`define DSX_A_RES    12'h014
`define DSX_A_ACCAL  12'h018
`define DSX_A_ACCAH  12'h01c
`define DSX_A_ACCBL  12'h020
`define DSX_A_ACCBH  12'h024
`define DSX_A_ISTAT  12'h028
`define DSX_A_IMASK  12'h02c
`define DSX_CTRL_ACC 4
`define DSX_CTRL_SRC 5
`define DSX_ST_C     0
`define DSX_ST_DC    1
`define DSX_ST_N     2
`define DSX_ST_OV    3
`define DSX_ST_Z     4
`define DSX_ST_OA    5
`define DSX_ST_SA    6
`define DSX_ST_OB    7
`define DSX_ST_SB    8
`define DSX_ST_BUSY  9
`define DSX_STAT_RST 9'h000
`define DSX_IRQ_DONE 0
`define DSX_IRQ_ACC  1
`define DSX_ACC_MAX  40'h7fffffffff
`define DSX_ACC_MIN  40'h8000000000
`define DSX_C_ACCUMULATOR_ARITH_SHIFT  4'h0
`define DSX_C_SLREG  4'h1
`define DSX_C_SLLIT  4'h2
`define DSX_C_SUBTRACT_WITH_BORROW   4'h3
`define DSX_C_SUBBL  4'h4
`define DSX_C_REVERSE_SUBTRACT_WITH_BORROW  4'h5
`define DSX_C_SUBBRL 4'h6
`define DSX_C_RDH    4'h7
`define DSX_C_RDL    4'h8
`define DSX_C_WTH    4'h9
`define DSX_C_WTL    4'ha
`define DSX_C_ZE     4'hb
`endif

// [dsx_pkg.sv]
// Types and opcode decoding of the datapath.
// Assumes dsx_cfg.svh for the opcode codes.
`include "dsx_cfg.svh"
package dsx_pkg;
   typedef enum logic [3:0] {
      op_accumulator_arith_shift, op_left_shift_reg, op_left_shift_lit,
      op_subtract_with_borrow, op_subtract_with_borrow_lit,
      op_reverse_subtract_with_borrow, op_reverse_subtract_with_borrow_lit,
      op_table_read_high, op_table_read_low, op_table_write_high,
      op_table_write_low, op_zero_extend_op
   } dsx_op_t;
   typedef enum logic [1:0] {st_idle, st_exec, st_tbl_issue, st_tbl_data} dsx_state_t;
   typedef struct packed {
      logic [15:0] res;
      logic        c;
      logic        dc;
      logic        ov;
   } dsx_sub_t;

   function automatic logic code_legal(input logic [3:0] code);
      code_legal = (code <= `DSX_C_ZE);
   endfunction : code_legal

   function automatic dsx_op_t code_to_op(input logic [3:0] code);
      case (code)
         `DSX_C_SLREG:  code_to_op = op_left_shift_reg;
         `DSX_C_SLLIT:  code_to_op = op_left_shift_lit;
         `DSX_C_SUBTRACT_WITH_BORROW:   code_to_op = op_subtract_with_borrow;
         `DSX_C_SUBBL:  code_to_op = op_subtract_with_borrow_lit;
         `DSX_C_REVERSE_SUBTRACT_WITH_BORROW:  code_to_op = op_reverse_subtract_with_borrow;
         `DSX_C_SUBBRL: code_to_op = op_reverse_subtract_with_borrow_lit;
         `DSX_C_RDH:    code_to_op = op_table_read_high;
         `DSX_C_RDL:    code_to_op = op_table_read_low;
         `DSX_C_WTH:    code_to_op = op_table_write_high;
         `DSX_C_WTL:    code_to_op = op_table_write_low;
         `DSX_C_ZE:     code_to_op = op_zero_extend_op;
         default:       code_to_op = op_accumulator_arith_shift;
      endcase
   endfunction : code_to_op

   function automatic logic is_table(input dsx_op_t op);
      is_table = (op == op_table_read_high) || (op == op_table_read_low) ||
                 (op == op_table_write_high) || (op == op_table_write_low);
   endfunction : is_table
endpackage : dsx_pkg

// [dsx_alu_if.sv]
// Carrier between the sequencing core and the combinational datapath.
// Assumes the core drives operands and reads results in the same cycle.
`timescale 1ns/100ps
interface dsx_alu_if;
   dsx_pkg::dsx_op_t op;
   logic [15:0]      opa;
   logic [15:0]      opb;
   logic [9:0]       lit;
   logic             cin;
   logic             use_reg;
   logic [39:0]      acc_in;
   logic [15:0]      res;
   logic             c;
   logic             dc;
   logic             n;
   logic             ov;
   logic             z;
   logic [39:0]      acc_out;
   logic             oa;
   logic             sa;
   modport core (output op, opa, opb, lit, cin, use_reg, acc_in,
                 input res, c, dc, n, ov, z, acc_out, oa, sa);
   modport alu  (input op, opa, opb, lit, cin, use_reg, acc_in,
                 output res, c, dc, n, ov, z, acc_out, oa, sa);
endinterface : dsx_alu_if

// [dsx_alu.sv]
// Combinational datapath: shifts, borrow subtracts, zero extension.
// Assumes the core commits results and picks which flags to keep.
`timescale 1ns/100ps
module dsx_alu (
   dsx_alu_if.alu bus
);
   import dsx_pkg::*;

   function automatic dsx_sub_t sub_borrow(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic        cin);
      logic [16:0] s;
      logic [4:0]  lo;
      s  = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
      lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      sub_borrow.res = s[15:0];
      sub_borrow.c   = s[16];
      sub_borrow.dc  = lo[4];
      sub_borrow.ov  = (a[15] != b[15]) && (s[15] != a[15]);
   endfunction : sub_borrow

   dsx_sub_t          sub;
   logic signed [5:0] amt;
   logic [5:0]        mag;
   logic signed [71:0] wide;

   always_comb begin
      sub         = '0;
      amt         = bus.use_reg ? bus.opb[5:0] : bus.lit[5:0];
      mag         = 6'(-amt);
      wide        = {{32{bus.acc_in[39]}}, bus.acc_in};
      bus.res     = 16'h0000;
      bus.c       = bus.cin;
      bus.dc      = 1'b0;
      bus.ov      = 1'b0;
      bus.acc_out = bus.acc_in;
      bus.sa      = 1'b0;
      unique case (bus.op)
         op_accumulator_arith_shift: begin
            // Positive amount shifts right, negative shifts left
            wide = amt[5] ? (wide <<< mag) : (wide >>> amt);
            bus.sa = !(&wide[71:39] || !(|wide[71:39]));
            bus.acc_out = bus.sa ? (wide[71] ? `DSX_ACC_MIN : `DSX_ACC_MAX) : wide[39:0];
         end
         op_left_shift_reg:  bus.res = 16'(bus.opa << bus.opb[4:0]);
         op_left_shift_lit:  bus.res = 16'(bus.opa << bus.lit[4:0]);
         op_subtract_with_borrow:
            sub = sub_borrow(bus.opa, bus.opb, bus.cin);
         op_subtract_with_borrow_lit:
            sub = sub_borrow(bus.opa, {6'h00, bus.lit}, bus.cin);
         op_reverse_subtract_with_borrow:
            sub = sub_borrow(bus.opb, bus.opa, bus.cin);
         op_reverse_subtract_with_borrow_lit:
            sub = sub_borrow({11'h000, bus.lit[4:0]}, bus.opa, bus.cin);
         op_zero_extend_op: begin
            bus.res = {8'h00, bus.opa[7:0]};
            bus.c   = 1'b1;
         end
         op_table_read_high, op_table_read_low,
         op_table_write_high, op_table_write_low: bus.res = 16'h0000;
      endcase
      if (bus.op inside {op_subtract_with_borrow, op_subtract_with_borrow_lit,
                         op_reverse_subtract_with_borrow,
                         op_reverse_subtract_with_borrow_lit}) begin
         bus.res = sub.res;
         bus.c   = sub.c;
         bus.dc  = sub.dc;
         bus.ov  = sub.ov;
      end
   end

   assign bus.n  = bus.res[15];
   assign bus.z  = (bus.res == 16'h0000);
   assign bus.oa = !(&bus.acc_out[39:31] || !(|bus.acc_out[39:31]));
endmodule : dsx_alu

// [dsx_core.sv]
// Top of the shift/subtract/table execution datapath with APB registers.
// Assumes a synchronous program memory that returns data one cycle after a read strobe.
`timescale 1ns/100ps
`include "dsx_cfg.svh"
module dsx_core (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [15:0] prog_addr,
   output logic             prog_rd,
   output logic             prog_wr_lo,
   output logic             prog_wr_hi,
   output logic      [23:0] prog_wdata,
   input  wire logic [23:0] prog_rdata,
   output logic             irq
);
   import dsx_pkg::*;

   dsx_alu_if  alu_bus ();
   dsx_state_t state_ff;
   dsx_op_t    op_ff;
   logic [5:0]  ctrl_ff;
   logic [15:0] opa_ff;
   logic [15:0] opb_ff;
   logic [9:0]  lit_ff;
   logic [8:0]  stat_ff;
   logic [15:0] result_ff;
   logic [39:0] acca_ff;
   logic [39:0] accb_ff;
   logic [1:0]  istat_ff;
   logic [1:0]  imask_ff;
   logic [1:0]  nxt_istat;
   logic [1:0]  nxt_imask;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [15:0] prog_addr_ff;
   logic        prog_rd_ff;
   logic        prog_wr_lo_ff;
   logic        prog_wr_hi_ff;
   logic [23:0] prog_wdata_ff;
   logic        irq_ff;
   logic [31:0] rd_data;
   logic        rd_hit;
   logic        acc_ph;
   logic        wr_fin;
   logic        rd_fin;
   logic        idle;
   logic        start;
   logic        in_exec;
   dsx_op_t     start_op;

   // Access phase answers one cycle late so read data and pready both come from flops
   assign acc_ph   = psel && penable && !pready_ff;
   assign wr_fin   = psel && penable && pready_ff && pwrite;
   assign rd_fin   = psel && penable && pready_ff && !pwrite;
   assign idle     = (state_ff == st_idle);
   assign in_exec  = (state_ff == st_exec);
   assign start_op = code_to_op(pwdata[3:0]);
   assign start    = wr_fin && (paddr == `DSX_A_CTRL) && idle && code_legal(pwdata[3:0]);

   assign alu_bus.op      = op_ff;
   assign alu_bus.opa     = opa_ff;
   assign alu_bus.opb     = opb_ff;
   assign alu_bus.lit     = lit_ff;
   assign alu_bus.cin     = stat_ff[`DSX_ST_C];
   assign alu_bus.use_reg = ctrl_ff[`DSX_CTRL_SRC];
   assign alu_bus.acc_in  = ctrl_ff[`DSX_CTRL_ACC] ? accb_ff : acca_ff;

   dsx_alu u_alu (
      .bus (alu_bus.alu)
   );

   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h00000000;
      unique case (paddr)
         `DSX_A_CTRL:  rd_data = {26'h0000000, ctrl_ff};
         `DSX_A_OPA:   rd_data = {16'h0000, opa_ff};
         `DSX_A_OPB:   rd_data = {16'h0000, opb_ff};
         `DSX_A_LIT:   rd_data = {22'h000000, lit_ff};
         `DSX_A_STAT:  rd_data = {22'h000000, !idle, stat_ff};
         `DSX_A_RES:   rd_data = {16'h0000, result_ff};
         `DSX_A_ACCAL: rd_data = acca_ff[31:0];
         `DSX_A_ACCAH: rd_data = {24'h000000, acca_ff[39:32]};
         `DSX_A_ACCBL: rd_data = accb_ff[31:0];
         `DSX_A_ACCBH: rd_data = {24'h000000, accb_ff[39:32]};
         `DSX_A_ISTAT: rd_data = {30'h00000000, istat_ff};
         `DSX_A_IMASK: rd_data = {30'h00000000, imask_ff};
         default:      rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= acc_ph;
         if (acc_ph) begin
            prdata_ff  <= pwrite ? 32'h00000000 : rd_data;
            pslverr_ff <= !rd_hit;
         end
      end
   end

   // Operand registers may change while busy; table address is latched at start
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff <= 6'h00;
         opa_ff  <= 16'h0000;
         opb_ff  <= 16'h0000;
         lit_ff  <= 10'h000;
      end else begin
         if (wr_fin && paddr == `DSX_A_CTRL && idle)
            ctrl_ff <= pwdata[5:0];
         if (wr_fin && paddr == `DSX_A_OPA)
            opa_ff <= pwdata[15:0];
         if (wr_fin && paddr == `DSX_A_OPB)
            opb_ff <= pwdata[15:0];
         if (wr_fin && paddr == `DSX_A_LIT)
            lit_ff <= pwdata[9:0];
         if (in_exec && op_ff == op_subtract_with_borrow_lit)
            opa_ff <= alu_bus.res;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= st_idle;
         op_ff    <= op_accumulator_arith_shift;
      end else begin
         unique case (state_ff)
            st_idle: if (start) begin
               op_ff    <= start_op;
               state_ff <= is_table(start_op) ? st_tbl_issue : st_exec;
            end
            st_exec:      state_ff <= st_idle;
            st_tbl_issue: state_ff <= st_tbl_data;
            st_tbl_data:  state_ff <= st_idle;
         endcase
      end
   end

   // Strobes are single-cycle pulses issued at the start edge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prog_addr_ff  <= 16'h0000;
         prog_wdata_ff <= 24'h000000;
         prog_rd_ff    <= 1'b0;
         prog_wr_hi_ff <= 1'b0;
         prog_wr_lo_ff <= 1'b0;
      end else begin
         prog_rd_ff    <= start && (start_op inside {op_table_read_high, op_table_read_low});
         prog_wr_hi_ff <= start && (start_op == op_table_write_high);
         prog_wr_lo_ff <= start && (start_op == op_table_write_low);
         if (start && is_table(start_op)) begin
            prog_addr_ff  <= opa_ff;
            prog_wdata_ff <= {opb_ff[7:0], opb_ff};
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         result_ff <= 16'h0000;
      end else if (in_exec && op_ff != op_accumulator_arith_shift) begin
         result_ff <= alu_bus.res;
      end else if (state_ff == st_tbl_data) begin
         if (op_ff == op_table_read_high)
            result_ff <= {8'h00, prog_rdata[23:16]};
         else if (op_ff == op_table_read_low)
            result_ff <= prog_rdata[15:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         acca_ff <= 40'h0000000000;
         accb_ff <= 40'h0000000000;
      end else if (in_exec && op_ff == op_accumulator_arith_shift) begin
         if (ctrl_ff[`DSX_CTRL_ACC])
            accb_ff <= alu_bus.acc_out;
         else
            acca_ff <= alu_bus.acc_out;
      end else if (wr_fin && idle) begin
         if (paddr == `DSX_A_ACCAL)
            acca_ff[31:0] <= pwdata;
         if (paddr == `DSX_A_ACCAH)
            acca_ff[39:32] <= pwdata[7:0];
         if (paddr == `DSX_A_ACCBL)
            accb_ff[31:0] <= pwdata;
         if (paddr == `DSX_A_ACCBH)
            accb_ff[39:32] <= pwdata[7:0];
      end
   end

   // Software may load the flags only while idle, so it never races an update
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stat_ff <= `DSX_STAT_RST;
      end else if (in_exec) begin
         unique case (op_ff)
            op_accumulator_arith_shift: begin
               if (ctrl_ff[`DSX_CTRL_ACC]) begin
                  stat_ff[`DSX_ST_OB] <= alu_bus.oa;
                  stat_ff[`DSX_ST_SB] <= alu_bus.sa;
               end else begin
                  stat_ff[`DSX_ST_OA] <= alu_bus.oa;
                  stat_ff[`DSX_ST_SA] <= alu_bus.sa;
               end
            end
            op_left_shift_reg, op_left_shift_lit: begin
               stat_ff[`DSX_ST_N] <= alu_bus.n;
               stat_ff[`DSX_ST_Z] <= alu_bus.z;
            end
            op_zero_extend_op: begin
               stat_ff[`DSX_ST_C] <= alu_bus.c;
               stat_ff[`DSX_ST_N] <= alu_bus.n;
               stat_ff[`DSX_ST_Z] <= alu_bus.z;
            end
            op_subtract_with_borrow, op_subtract_with_borrow_lit,
            op_reverse_subtract_with_borrow, op_reverse_subtract_with_borrow_lit: begin
               stat_ff[`DSX_ST_C]  <= alu_bus.c;
               stat_ff[`DSX_ST_DC] <= alu_bus.dc;
               stat_ff[`DSX_ST_N]  <= alu_bus.n;
               stat_ff[`DSX_ST_OV] <= alu_bus.ov;
               stat_ff[`DSX_ST_Z]  <= alu_bus.z;
            end
            op_table_read_high, op_table_read_low,
            op_table_write_high, op_table_write_low: stat_ff <= stat_ff;
         endcase
      end else if (wr_fin && idle && paddr == `DSX_A_STAT) begin
         stat_ff <= pwdata[8:0];
      end
   end

   // Read clears only the bits that were returned, and a new event wins the clear
   always_comb begin
      nxt_istat = istat_ff;
      nxt_imask = imask_ff;
      if (rd_fin && paddr == `DSX_A_ISTAT)
         nxt_istat = istat_ff & ~prdata_ff[1:0];
      if (wr_fin && paddr == `DSX_A_IMASK)
         nxt_imask = pwdata[1:0];
      if (in_exec || state_ff == st_tbl_data)
         nxt_istat[`DSX_IRQ_DONE] = 1'b1;
      if (in_exec && op_ff == op_accumulator_arith_shift && (alu_bus.oa || alu_bus.sa))
         nxt_istat[`DSX_IRQ_ACC] = 1'b1;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         istat_ff <= 2'h0;
         imask_ff <= 2'h0;
         irq_ff   <= 1'b0;
      end else begin
         istat_ff <= nxt_istat;
         imask_ff <= nxt_imask;
         irq_ff   <= |(nxt_istat & nxt_imask);
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign prog_addr  = prog_addr_ff;
   assign prog_rd    = prog_rd_ff;
   assign prog_wr_lo = prog_wr_lo_ff;
   assign prog_wr_hi = prog_wr_hi_ff;
   assign prog_wdata = prog_wdata_ff;
   assign irq        = irq_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_tbl_start(dsx_op_t o);
      start && start_op == o;
   endsequence
   sequence s_tbl_done;
      state_ff == st_tbl_issue ##1 state_ff == st_tbl_data;
   endsequence

   a_accumulator_arith_shift_one_cycle: assert property (
      (in_exec && op_ff == op_accumulator_arith_shift) |=> idle && istat_ff[`DSX_IRQ_DONE])
      else $error("accumulator shift did not finish in one cycle");
   a_sl_reg_flags: assert property (
      (in_exec && op_ff == op_left_shift_reg) |=> result_ff == 16'($past(opa_ff) << $past(opb_ff[4:0]))
         && $stable(stat_ff[`DSX_ST_C]) && $stable(stat_ff[`DSX_ST_OV]))
      else $error("register-count left shift wrong");
   a_sl_lit_value: assert property (
      (in_exec && op_ff == op_left_shift_lit) |=> result_ff == 16'($past(opa_ff) << $past(lit_ff[4:0]))
         && stat_ff[`DSX_ST_Z] == (result_ff == 16'h0000))
      else $error("literal left shift wrong");
   a_subtract_with_borrow_value: assert property (
      (in_exec && op_ff == op_subtract_with_borrow) |=>
         result_ff == 16'($past(opa_ff) - $past(opb_ff) - {15'h0000, !$past(stat_ff[`DSX_ST_C])}))
      else $error("borrow subtract result wrong");
   a_subtract_with_borrow_lit_value: assert property (
      (in_exec && op_ff == op_subtract_with_borrow_lit) |=>
         result_ff == 16'($past(opa_ff) - {6'h00, $past(lit_ff)} - {15'h0000, !$past(stat_ff[`DSX_ST_C])})
         && opa_ff == result_ff)
      else $error("literal borrow subtract result wrong");
   a_reverse_subtract_with_borrow_value: assert property (
      (in_exec && op_ff == op_reverse_subtract_with_borrow) |=>
         result_ff == 16'($past(opb_ff) - $past(opa_ff) - {15'h0000, !$past(stat_ff[`DSX_ST_C])}))
      else $error("reverse borrow subtract result wrong");
   a_reverse_subtract_with_borrow_lit_value: assert property (
      (in_exec && op_ff == op_reverse_subtract_with_borrow_lit) |=>
         result_ff == 16'({11'h000, $past(lit_ff[4:0])} - $past(opa_ff) - {15'h0000, !$past(stat_ff[`DSX_ST_C])}))
      else $error("literal reverse borrow subtract wrong");
   a_rdh_high_byte: assert property (
      s_tbl_start(op_table_read_high) ##1 s_tbl_done |=>
         result_ff == {8'h00, $past(prog_rdata[23:16])} && idle)
      else $error("table read high wrong");
   a_rdl_low_word: assert property (
      s_tbl_start(op_table_read_low) |=> prog_rd ##1 1'b1 ##1 result_ff == $past(prog_rdata[15:0]))
      else $error("table read low wrong");
   a_wth_strobe: assert property (
      s_tbl_start(op_table_write_high) |=> prog_wr_hi && !prog_wr_lo
         && prog_wdata[23:16] == $past(opb_ff[7:0]) ##1 !prog_wr_hi ##1 idle)
      else $error("table write high wrong");
   a_wtl_strobe: assert property (
      s_tbl_start(op_table_write_low) |=> prog_wr_lo && !prog_wr_hi
         && prog_wdata[15:0] == $past(opb_ff) ##1 !prog_wr_lo ##1 idle)
      else $error("table write low wrong");
   a_ze_value: assert property (
      (in_exec && op_ff == op_zero_extend_op) |=> result_ff == {8'h00, $past(opa_ff[7:0])}
         && stat_ff[`DSX_ST_C] && !stat_ff[`DSX_ST_N])
      else $error("zero extend wrong");
   a_rdh_upper_zero: assert property (
      (state_ff == st_tbl_data && op_ff == op_table_read_high) |=> result_ff[15:8] == 8'h00)
      else $error("table read high upper byte not zero");
   a_tbl_flags_kept: assert property (
      (start && is_table(start_op)) |=> $stable(stat_ff) [*2])
      else $error("table instruction changed flags");
endmodule : dsx_core

// [dsx_prog_mem.sv]
// Program memory model on the far side of the table port.
// Assumes strobes are single-cycle pulses from the datapath.
`timescale 1ns/100ps
module dsx_prog_mem (
   input  wire logic        clock,
   input  wire logic [15:0] prog_addr,
   input  wire logic        prog_rd,
   input  wire logic        prog_wr_lo,
   input  wire logic        prog_wr_hi,
   input  wire logic [23:0] prog_wdata,
   output logic      [23:0] prog_rdata
);
   logic [23:0] mem [0:15];
   initial prog_rdata = 24'h0;
   always @(posedge clock) begin
      if (prog_wr_lo) mem[prog_addr[3:0]][15:0] <= prog_wdata[15:0];
      if (prog_wr_hi) mem[prog_addr[3:0]][23:16] <= prog_wdata[23:16];
      // Stale data toggles so a late capture cannot pass by luck
      prog_rdata <= prog_rd ? mem[prog_addr[3:0]] : ~prog_rdata;
   end
endmodule : dsx_prog_mem

// [testbench.sv]
// Self-checking bench: APB master, read scoreboard, program memory model.
// Assumes irq with done unmasked marks completion of each operation.
`timescale 1ns/100ps
`include "dsx_cfg.svh"
module testbench;
   logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, ci;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, v;
   logic [15:0] prog_addr, a, b, r;
   logic prog_rd, prog_wr_lo, prog_wr_hi;
   logic [23:0] prog_wdata, prog_rdata;
   logic [32:0] e, q[$];
   logic [20:0] ex;
   logic [9:0] l;
   logic [4:0] st;
   logic [10:0] pd;
   int error_cnt = 0, checks_done = 0, k;
   integer seed = 32'hf727d342;
`define CHK(nm, xe, xs) begin checks_done++; if ((xe) !== (xs)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, xe, xs); end end
   dsx_core DUT (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_wr_lo(prog_wr_lo), .prog_wr_hi(prog_wr_hi),
      .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .irq(irq));
   dsx_prog_mem mem (.clock(clock), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_wr_lo(prog_wr_lo),
      .prog_wr_hi(prog_wr_hi), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata));
   initial forever #5 clock = ~clock;
   always @(posedge clock) if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = q.pop_front();
      `CHK("read", e, {pslverr, prdata})
   end
   task complete_run;
      if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] x);
      int n;
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
      if (!w) q.push_back(x);
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin error_cnt++; complete_run(); end
      psel <= 0; penable <= 0;
   endtask : apb
   task wr(input logic [11:0] ad, input logic [31:0] d);
      apb(1, ad, d, 0);
   endtask : wr
   task rd(input logic [11:0] ad, input logic [31:0] x);
      apb(0, ad, 0, {1'b0, x});
   endtask : rd
   task ld;
      wr(`DSX_A_OPA, {16'h0, a});
      wr(`DSX_A_OPB, {16'h0, b});
      wr(`DSX_A_LIT, {22'h0, l});
      wr(`DSX_A_STAT, {27'h0, st});
   endtask : ld
   task op(input logic [31:0] c, input logic [1:0] x = 2'h1);
      int n;
      wr(`DSX_A_CTRL, c);
      n = 0;
      while (irq !== 1'b1 && n < 20) begin @(posedge clock); n++; end
      if (n >= 20) begin error_cnt++; complete_run(); end
      rd(`DSX_A_ISTAT, {30'h0, x});
      repeat (2) @(posedge clock);
      `CHK("irq", 1'b0, irq)
   endtask : op
   function automatic logic [20:0] sb(input logic [15:0] x, y, input logic c);
      logic [16:0] t;
      logic [4:0] h;
      t = x + {1'b0, ~y} + c;
      h = x[3:0] + {1'b0, ~y[3:0]} + c;
      sb = {t[15:0] == 0, (x[15] != y[15]) && (t[15] != x[15]), t[15], h[4], t[16], t[15:0]};
   endfunction : sb
   initial begin
      repeat (2) @(posedge clock);
      arst_n <= 1;
      rd(`DSX_A_STAT, 0);
      apb(0, 12'h030, 0, {1'b1, 32'h0});
      wr(`DSX_A_IMASK, 1);
      for (k = 1; k < 12; k++) begin
         {a, b} = $random(seed);
         {l, st, ci, pd} = $random(seed);
         ld();
         if (k > 2 && k < 7) begin
            ex = (k == 3) ? sb(a, b, ci) : (k == 4) ? sb(a, {6'h0, l}, ci) : (k == 5) ? sb(b, a, ci) :
               sb({11'h0, l[4:0]}, a, ci);
            wr(`DSX_A_STAT, {31'h0, ci});
            op(k);
            rd(`DSX_A_RES, {16'h0, ex[15:0]});
            rd(`DSX_A_STAT, {27'h0, ex[20:16]});
            if (k == 4)
               rd(`DSX_A_OPA, {16'h0, ex[15:0]});
         end else if (k < 3) begin
            r = ((k == 1 ? b[4:0] : l[4:0]) > 15) ? 16'h0 : a << (k == 1 ? b[4:0] : l[4:0]);
            op(k);
            rd(`DSX_A_RES, {16'h0, r});
            rd(`DSX_A_STAT, {27'h0, r == 0, st[3], r[15], st[1:0]});
         end
      end
      op(11);
      rd(`DSX_A_RES, {24'h0, a[7:0]});
      rd(`DSX_A_STAT, {27'h0, a[7:0] == 0, st[3], 1'b0, st[1], 1'b1});
      ld();
      op(10);
      op(9);
      rd(`DSX_A_STAT, {27'h0, st});
      op(8);
      rd(`DSX_A_RES, {16'h0, b});
      op(7);
      rd(`DSX_A_RES, {24'h0, b[7:0]});
      rd(`DSX_A_STAT, {27'h0, st});
      v = $random(seed) & 32'h3fff_fffe;
      {b, l, st} = {16'h003f, 10'h1, 5'h0};
      ld();
      wr(`DSX_A_ACCAL, v);
      wr(`DSX_A_ACCAH, 0);
      op(0);
      rd(`DSX_A_ACCAL, v >> 1);
      op(32'h20);
      rd(`DSX_A_ACCAL, v);
      rd(`DSX_A_STAT, 0);
      // Accumulator B left by one from a large positive value must saturate
      {b, l, st} = {16'h0000, 10'h03f, 5'h0};
      ld();
      wr(`DSX_A_ACCBH, 32'h40);
      op(32'h10, 2'h3);
      rd(`DSX_A_ACCBL, 32'hffffffff);
      rd(`DSX_A_ACCBH, 32'h7f);
      rd(`DSX_A_STAT, 32'h180);
      rd(`DSX_A_ACCAL, v);
      // An illegal opcode is stored but starts nothing
      wr(`DSX_A_CTRL, 32'h0c);
      rd(`DSX_A_CTRL, 32'h0c);
      rd(`DSX_A_ISTAT, 0);
      complete_run();
   end
endmodule : testbench
